//--- rtl/dmact_pkg.sv
// constants and types for the dma channel trigger, address and count slice
package dmact_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_ADDR_W = 3;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned NUM_REQ = 256;
  localparam int unsigned COUNT_W = 14;
  localparam int unsigned PADDR_W = 16;
  localparam logic [REG_ADDR_W-1:0] OFF_TRIGGER = 3'h0;
  localparam logic [REG_ADDR_W-1:0] OFF_PADDR = 3'h1;
  localparam logic [REG_ADDR_W-1:0] OFF_COUNT = 3'h2;
  localparam logic [REG_ADDR_W-1:0] OFF_CTRL = 3'h3;
  localparam logic [REG_ADDR_W-1:0] OFF_STATUS = 3'h4;
  localparam int unsigned FORCE_BIT = 15;
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned BUSY_BIT = 15;
  localparam int unsigned PEND_BIT = 14;
  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
  localparam logic [PADDR_W-1:0] PADDR_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;

  typedef enum {DMACT_IDLE, DMACT_WAIT_ACK} dmact_state_e;

  typedef struct packed {
    logic [PADDR_W-1:0] addr;
    logic [COUNT_W-1:0] index;
    logic forced;
  } dmact_xfer_s;
endpackage : dmact_pkg

//--- rtl/dmact_channel.sv
// per-channel dma trigger, peripheral address and transfer count control
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - software writing zero to the manual trigger bit changes nothing
// - manual trigger bit clears when its transfer finishes or channel is disabled
// - 16-bit read/write peripheral address register, reset zero, drives transfer address
// - 14-bit read/write transfer count, bits 15-14 read zero, reset zero
// - each block performs count plus one transfers
module dmact_channel (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [dmact_pkg::REG_ADDR_W-1:0] reg_addr, // register index
  input wire logic [dmact_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [dmact_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic [dmact_pkg::NUM_REQ-1:0] periph_req, // peripheral request pulses
  output logic xfer_valid, // transfer request to data mover
  output dmact_pkg::dmact_xfer_s xfer, // transfer descriptor
  input wire logic xfer_ack, // data mover finished the transfer
  output logic block_done, // last transfer of a block finished
  output logic channel_enable // channel enable as programmed
);
  logic force_bit;
  logic [dmact_pkg::SEL_W-1:0] request_source_select;
  logic [dmact_pkg::PADDR_W-1:0] channel_peripheral_address;
  logic [dmact_pkg::COUNT_W-1:0] transfer_count;
  logic [dmact_pkg::COUNT_W-1:0] xfer_index;
  logic auto_pend;
  dmact_pkg::dmact_state_e state;

  // register decode
  wire logic wr_trig = reg_wr && (reg_addr == dmact_pkg::OFF_TRIGGER);
  wire logic wr_paddr = reg_wr && (reg_addr == dmact_pkg::OFF_PADDR);
  wire logic wr_count = reg_wr && (reg_addr == dmact_pkg::OFF_COUNT);
  wire logic wr_ctrl = reg_wr && (reg_addr == dmact_pkg::OFF_CTRL);
  wire logic force_set = wr_trig && reg_wdata[dmact_pkg::FORCE_BIT];
  wire logic idle = (state == dmact_pkg::DMACT_IDLE);
  wire logic waiting = (state == dmact_pkg::DMACT_WAIT_ACK);
  wire logic finish = waiting && xfer_ack;
  wire logic finish_forced = finish && xfer.forced;
  wire logic last_xfer = (xfer_index == transfer_count);
  wire logic sel_req = periph_req[request_source_select];
  wire logic issue = idle && channel_enable && (force_bit || auto_pend);
  wire logic issue_auto = issue && !force_bit;

  // manual trigger: set wins over the hardware clear, disable clears it
  wire logic next_force = !channel_enable ? 1'b0 :
    force_set ? 1'b1 :
    finish_forced ? 1'b0 : force_bit;

  // automatic request latch, set wins over the consume
  wire logic next_auto_pend = !channel_enable ? 1'b0 :
    (sel_req && !force_bit) ? 1'b1 :
    issue_auto ? 1'b0 : auto_pend;

  wire logic [dmact_pkg::COUNT_W-1:0] next_index =
    !channel_enable ? dmact_pkg::COUNT_RESET :
    !finish ? xfer_index :
    last_xfer ? dmact_pkg::COUNT_RESET : xfer_index + dmact_pkg::COUNT_ONE;

  // read mux, unmapped indexes read zero
  wire logic [dmact_pkg::DATA_W-1:0] trig_word =
    {force_bit, 7'h00, request_source_select};
  wire logic [dmact_pkg::DATA_W-1:0] count_word = {2'h0, transfer_count};
  wire logic [dmact_pkg::DATA_W-1:0] ctrl_word = {15'h0000, channel_enable};
  wire logic [dmact_pkg::DATA_W-1:0] status_word = {waiting, auto_pend, xfer_index};
  wire logic [dmact_pkg::DATA_W-1:0] rd_word =
    (reg_addr == dmact_pkg::OFF_TRIGGER) ? trig_word :
    (reg_addr == dmact_pkg::OFF_PADDR) ? channel_peripheral_address :
    (reg_addr == dmact_pkg::OFF_COUNT) ? count_word :
    (reg_addr == dmact_pkg::OFF_CTRL) ? ctrl_word :
    (reg_addr == dmact_pkg::OFF_STATUS) ? status_word : dmact_pkg::RESET_WORD;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= dmact_pkg::RESET_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_word : dmact_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      request_source_select <= dmact_pkg::SEL_RESET;
      channel_peripheral_address <= dmact_pkg::PADDR_RESET;
      transfer_count <= dmact_pkg::COUNT_RESET;
      channel_enable <= 1'b0;
    end else begin
      if (wr_trig) begin
        request_source_select <= reg_wdata[dmact_pkg::SEL_W-1:0];
      end
      if (wr_paddr) begin
        channel_peripheral_address <= reg_wdata;
      end
      if (wr_count) begin
        transfer_count <= reg_wdata[dmact_pkg::COUNT_W-1:0];
      end
      if (wr_ctrl) begin
        channel_enable <= reg_wdata[dmact_pkg::ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      force_bit <= 1'b0;
      auto_pend <= 1'b0;
      xfer_index <= dmact_pkg::COUNT_RESET;
    end else begin
      force_bit <= next_force;
      auto_pend <= next_auto_pend;
      xfer_index <= next_index;
    end
  end

  // transfer sequencer: one transfer in flight at a time
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= dmact_pkg::DMACT_IDLE;
      xfer_valid <= 1'b0;
      xfer <= '0;
      block_done <= 1'b0;
    end else begin
      block_done <= 1'b0;
      case (state)
        dmact_pkg::DMACT_IDLE: begin
          if (issue) begin
            state <= dmact_pkg::DMACT_WAIT_ACK;
            xfer_valid <= 1'b1;
            xfer.addr <= channel_peripheral_address;
            xfer.index <= xfer_index;
            xfer.forced <= force_bit;
          end
        end
        dmact_pkg::DMACT_WAIT_ACK: begin
          if (!channel_enable) begin
            state <= dmact_pkg::DMACT_IDLE;
            xfer_valid <= 1'b0;
          end else if (xfer_ack) begin
            state <= dmact_pkg::DMACT_IDLE;
            xfer_valid <= 1'b0;
            block_done <= last_xfer;
          end
        end
        default: begin
          state <= dmact_pkg::DMACT_IDLE;
          xfer_valid <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_force_write;
    wr_trig && reg_wdata[dmact_pkg::FORCE_BIT] && channel_enable && idle && !auto_pend
      && !force_bit;
  endsequence

  sequence s_auto_req;
    idle && channel_enable && !force_bit && !auto_pend && sel_req && !reg_wr ##1
      channel_enable;
  endsequence

  property p_force_sw_clear_ignored;
    force_bit && channel_enable && wr_trig && !reg_wdata[dmact_pkg::FORCE_BIT]
      && !finish_forced && !wr_ctrl |=> force_bit;
  endproperty
  a_force_sw_clear_ignored: assert property (p_force_sw_clear_ignored)
    else $error("manual trigger bit cleared by software write");

  property p_force_hw_clear;
    finish_forced && channel_enable && !force_set |=> !force_bit && !xfer_valid;
  endproperty
  a_force_hw_clear: assert property (p_force_hw_clear)
    else $error("manual trigger bit not cleared after forced transfer");

  property p_force_disable_clear;
    !channel_enable |=> !force_bit;
  endproperty
  a_force_disable_clear: assert property (p_force_disable_clear)
    else $error("manual trigger bit survives disabled channel");

  property p_paddr_write_read;
    wr_paddr ##1 (reg_rd && reg_addr == dmact_pkg::OFF_PADDR && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_paddr_write_read: assert property (p_paddr_write_read)
    else $error("peripheral address readback mismatch");

  property p_count_upper_zero;
    reg_rd && reg_addr == dmact_pkg::OFF_COUNT |=>
      reg_rdata[dmact_pkg::DATA_W-1:dmact_pkg::COUNT_W] == '0
      && reg_rdata[dmact_pkg::COUNT_W-1:0] == $past(transfer_count);
  endproperty
  a_count_upper_zero: assert property (p_count_upper_zero)
    else $error("transfer count readback wrong");

  property p_block_end;
    finish && channel_enable && last_xfer |=> block_done
      && xfer_index == dmact_pkg::COUNT_RESET;
  endproperty
  a_block_end: assert property (p_block_end)
    else $error("block did not end after count plus one transfers");

  property p_block_not_early;
    finish && channel_enable && !last_xfer |=> !block_done
      && xfer_index == $past(xfer_index) + dmact_pkg::COUNT_ONE;
  endproperty
  a_block_not_early: assert property (p_block_not_early)
    else $error("block ended early or index did not advance");

  property p_force_starts;
    // bit lands on the write edge, issue follows one edge later
    s_force_write |=> ##1 (xfer_valid && xfer.forced);
  endproperty
  a_force_starts: assert property (p_force_starts)
    else $error("forced transfer did not start");

  property p_auto_starts;
    s_auto_req |=> xfer_valid && !xfer.forced;
  endproperty
  a_auto_starts: assert property (p_auto_starts)
    else $error("selected peripheral request did not start a transfer");

  property p_paddr_write_lands;
    wr_paddr |=> channel_peripheral_address == $past(reg_wdata);
  endproperty
  a_paddr_write_lands: assert property (p_paddr_write_lands)
    else $error("peripheral address write did not land");

  property p_paddr_read;
    reg_rd && reg_addr == dmact_pkg::OFF_PADDR |=> reg_rdata == $past(channel_peripheral_address);
  endproperty
  a_paddr_read: assert property (p_paddr_read)
    else $error("peripheral address read wrong");

  property p_count_write_lands;
    wr_count |=> transfer_count == $past(reg_wdata[dmact_pkg::COUNT_W-1:0]);
  endproperty
  a_count_write_lands: assert property (p_count_write_lands)
    else $error("transfer count write did not land");

  property p_trig_read;
    reg_rd && reg_addr == dmact_pkg::OFF_TRIGGER |=> reg_rdata[dmact_pkg::FORCE_BIT] == $past(force_bit)
      && reg_rdata[dmact_pkg::FORCE_BIT-1:dmact_pkg::SEL_W] == '0;
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("trigger register read wrong");

  property p_xfer_addr_copy;
    issue |=> xfer_valid && xfer.addr == $past(channel_peripheral_address);
  endproperty
  a_xfer_addr_copy: assert property (p_xfer_addr_copy)
    else $error("transfer address not taken from address register");

  property p_force_priority;
    issue && force_bit |=> xfer.forced;
  endproperty
  a_force_priority: assert property (p_force_priority)
    else $error("manual trigger did not take priority");

  property p_auto_unforced;
    issue && !force_bit |=> !xfer.forced;
  endproperty
  a_auto_unforced: assert property (p_auto_unforced)
    else $error("automatic transfer marked as forced");

  property p_xfer_holds;
    xfer_valid && !xfer_ack && channel_enable |=> xfer_valid && $stable(xfer);
  endproperty
  a_xfer_holds: assert property (p_xfer_holds)
    else $error("transfer request changed before acknowledge");

  property p_valid_drops_on_ack;
    waiting && xfer_ack |=> !xfer_valid;
  endproperty
  a_valid_drops_on_ack: assert property (p_valid_drops_on_ack)
    else $error("transfer request held after acknowledge");

  property p_disable_aborts;
    waiting && !channel_enable |=> !xfer_valid && !block_done;
  endproperty
  a_disable_aborts: assert property (p_disable_aborts)
    else $error("disabled channel kept its transfer");

  property p_disabled_idle;
    !channel_enable |=> !xfer_valid && !auto_pend
      && xfer_index == dmact_pkg::COUNT_RESET;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled channel not idle");

  property p_done_single;
    block_done |=> !block_done;
  endproperty
  a_done_single: assert property (p_done_single)
    else $error("block end pulse longer than one cycle");

  property p_pend_ignored_forced;
    force_bit && !auto_pend |=> !auto_pend;
  endproperty
  a_pend_ignored_forced: assert property (p_pend_ignored_forced)
    else $error("peripheral request latched while manual trigger set");

  property p_force_set_wins;
    force_set && channel_enable |=> force_bit;
  endproperty
  a_force_set_wins: assert property (p_force_set_wins)
    else $error("manual trigger write did not set the bit");
endmodule : dmact_channel

`default_nettype wire

//--- testbench/dmact_mover.sv
// data mover model that acknowledges transfer requests after a set delay
`timescale 1ns/100ps
`default_nettype none
module dmact_mover (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic xfer_valid, // transfer request from the channel
  input wire logic [7:0] ack_delay, // cycles to wait before acking
  output logic xfer_ack // one-cycle finish pulse
);
  logic [7:0] wait_count;
  logic acked;
  always_ff @(posedge clk) begin
    if (reset) begin
      xfer_ack <= 1'b0;
      wait_count <= 8'h00;
      acked <= 1'b0;
    end else begin
      xfer_ack <= 1'b0;
      if (!xfer_valid) begin
        wait_count <= 8'h00;
        acked <= 1'b0;
      end else if (!acked) begin
        // one ack per request, never before it is seen
        if (wait_count == ack_delay) begin
          xfer_ack <= 1'b1;
          acked <= 1'b1;
        end else begin
          wait_count <= wait_count + 8'h01;
        end
      end
    end
  end
endmodule : dmact_mover
`default_nettype wire

//--- testbench/tb_dmact_channel.sv
// register and transfer tests for the dma channel control slice
`timescale 1ns/100ps
`default_nettype none
module tb_dmact_channel;
  logic clk, reset, reg_wr, reg_rd, xfer_valid, xfer_ack, block_done, channel_enable;
  logic [dmact_pkg::REG_ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [255:0] periph_req;
  logic [7:0] ack_delay;
  dmact_pkg::dmact_xfer_s xfer;
  int miscompares, checks_done, n, i;
  dmact_channel dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .xfer_valid(xfer_valid), .xfer(xfer), .xfer_ack(xfer_ack), .block_done(block_done),
    .channel_enable(channel_enable));
  dmact_mover mover (.clk(clk), .reset(reset), .xfer_valid(xfer_valid),
    .ack_delay(ack_delay), .xfer_ack(xfer_ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [dmact_pkg::REG_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [dmact_pkg::REG_ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({16'h0000, reg_rdata}, {16'h0000, exp});
  endtask : rd
  // write then read with no gap between the strobes
  task wr_rd(input logic [dmact_pkg::REG_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({16'h0000, reg_rdata}, {16'h0000, d});
  endtask : wr_rd
  task wait_hi(input int sel);
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while ((sel == 0 ? xfer_valid : block_done) !== 1'b1 && i < 100);
    if (i >= 100) begin
      miscompares++;
      end_sim;
    end
  endtask : wait_hi
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 16'h0000;
    periph_req = '0;
    ack_delay = 8'h00;
    miscompares = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(dmact_pkg::OFF_TRIGGER, 16'h0000);
    rd(dmact_pkg::OFF_PADDR, 16'h0000);
    rd(dmact_pkg::OFF_COUNT, 16'h0000);
    wr_rd(dmact_pkg::OFF_PADDR, 16'h3c5a);
    wr(dmact_pkg::OFF_PADDR, 16'ha5c3);
    rd(dmact_pkg::OFF_PADDR, 16'ha5c3);
    wr(dmact_pkg::OFF_COUNT, 16'hffff);
    rd(dmact_pkg::OFF_COUNT, 16'h3fff);
    rd(3'h7, 16'h0000);
    $display("test registers done");
    wr(dmact_pkg::OFF_COUNT, 16'h0000);
    wr(dmact_pkg::OFF_CTRL, 16'h0001);
    rd(dmact_pkg::OFF_CTRL, 16'h0001);
    chk(32'(channel_enable), 32'h1);
    wr(dmact_pkg::OFF_TRIGGER, 16'h8000);
    wait_hi(0);
    chk(32'(xfer.forced), 32'h1);
    chk(32'(xfer.addr), 32'ha5c3);
    wait_hi(1);
    rd(dmact_pkg::OFF_TRIGGER, 16'h0000);
    $display("test forced done");
    ack_delay <= 8'h14;
    wr(dmact_pkg::OFF_TRIGGER, 16'h8000);
    wr(dmact_pkg::OFF_TRIGGER, 16'h0000);
    rd(dmact_pkg::OFF_TRIGGER, 16'h8000);
    rd(dmact_pkg::OFF_STATUS, 16'h8000);
    wr(dmact_pkg::OFF_CTRL, 16'h0000);
    rd(dmact_pkg::OFF_TRIGGER, 16'h0000);
    chk(32'(channel_enable), 32'h0);
    $display("test force clear done");
    ack_delay <= 8'h00;
    for (int c = 0; c < 4; c += 3) begin
      wr(dmact_pkg::OFF_CTRL, 16'h0000);
      wr(dmact_pkg::OFF_COUNT, 16'(c));
      wr(dmact_pkg::OFF_TRIGGER, 16'h0003);
      periph_req[3] <= 1'b1;
      wr(dmact_pkg::OFF_CTRL, 16'h0001);
      n = 0;
      i = 0;
      do begin
        @(posedge clk);
        #1;
        i++;
        if (xfer_valid === 1'b1 && xfer_ack === 1'b1) begin
          chk(32'(xfer.index), 32'(n));
          chk(32'(xfer.forced), 32'h0);
          n++;
        end
      end while (block_done !== 1'b1 && i < 200);
      if (i >= 200) begin
        miscompares++;
        end_sim;
      end
      chk(32'(n), 32'(c + 1));
      periph_req <= '0;
    end
    wr(dmact_pkg::OFF_CTRL, 16'h0000);
    $display("test blocks done");
    end_sim;
  end
endmodule : tb_dmact_channel
`default_nettype wire
